// file: hdl/pdc_defines.svh
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

// Clock of the converter control logic
`define PDC_CLOCK_PERIOD_NS 10

// Idle timeout, nominal figure, and its count of clock cycles
`define PDC_IDLE_TIMEOUT_MS 60
`define PDC_IDLE_CYC ((`PDC_IDLE_TIMEOUT_MS * 1000000) / `PDC_CLOCK_PERIOD_NS)

// Computation delay; shorter input periods are skipped
`define PDC_COMPUTE_DELAY_NS 3200
`define PDC_COMPUTE_CYC (`PDC_COMPUTE_DELAY_NS / `PDC_CLOCK_PERIOD_NS)

// Narrowest high and low pulse that are still measured, in cycles
`define PDC_MIN_HIGH_CYC 2
`define PDC_MIN_LOW_CYC 2

// Structure
`define PDC_RESOLUTION 12
`define PDC_COUNT_WIDTH 24
`define PDC_NUM_CH 2

`endif

// file: hdl/pdc_pkg.sv
package pdc_pkg;

    // Device-wide power sequence
    typedef enum logic [2:0] {
        PDC_SYS_RUN = 3'h1,
        PDC_SYS_SHUT = 3'h2,
        PDC_SYS_WAIT = 3'h4
    } pdc_sys_state_type;

endpackage

// file: hdl/pdc_top.sv
`timescale 1ns/1ps
`include "pdc_defines.svh"
// Summary of operation
// - Too short high pulse gives zero-scale code
// - Too short low pulse gives full-scale code
// - Undetected edge: skip update, keep code
// - Reset: zero-scale, or powered down if select
// - Internal reference selected: drive ref pin, gain 2x
// - External reference selected: full-scale from pin
// - Sample/hold: idle-low channel powers down alone
// - Internal reference off if external or both down
// - Shutdown low: channels and reference powered down
// - Reference off: reference pin high impedance
// - Transparent: resume as shutdown returns high
// - Sample/hold: stay down until first rising edge
// - Edge pair within timeout updates code
// - Sample/hold: waking output stays off until updated
// - Code is 2^N times high over period
// - Idle level sets zero, full or hold
// - Sample/hold: pair beyond timeout is ignored
// - Period below compute delay skips update
module pdc_top
    import pdc_pkg::*;
#(
    parameter int RES = `PDC_RESOLUTION,
    parameter int CW = `PDC_COUNT_WIDTH,
    parameter int IDLE_CYC = `PDC_IDLE_CYC,
    parameter int MIN_HIGH_CYC = `PDC_MIN_HIGH_CYC,
    parameter int MIN_LOW_CYC = `PDC_MIN_LOW_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [`PDC_NUM_CH-1:0] pwm_in,
    input wire logic idle_behaviour_select,
    input wire logic reference_source_select,
    input wire logic shutdown_n,
    output logic [RES-1:0] dac_code_a,
    output logic [RES-1:0] dac_code_b,
    output logic [`PDC_NUM_CH-1:0] dac_drive_en,
    output logic [`PDC_NUM_CH-1:0] code_update,
    output logic internal_ref_enable,
    output logic ref_pin_oe,
    output logic ref_external,
    output logic ref_gain_double
);

    localparam int NCH = `PDC_NUM_CH;
    localparam int SW = $clog2(RES + 1);
    localparam logic [CW-1:0] IDLE_LIM = CW'(IDLE_CYC);
    localparam logic [CW-1:0] COMP_LIM = CW'(`PDC_COMPUTE_CYC);
    localparam logic [CW-1:0] HIGH_LIM = CW'(MIN_HIGH_CYC);
    localparam logic [CW-1:0] LOW_LIM = CW'(MIN_LOW_CYC);
    localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
    localparam logic [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
    localparam logic [RES-1:0] CODE_FULL = {RES{1'b1}};
    localparam logic [RES-1:0] CODE_ZERO = {RES{1'b0}};
    localparam logic [SW-1:0] STEPS = SW'(RES);
    localparam logic [SW-1:0] STEP_ONE = {{(SW-1){1'b0}}, 1'b1};

    pdc_sys_state_type sys_state;
    pdc_sys_state_type next_sys_state;

    logic [NCH-1:0] rise_vec;
    logic [NCH-1:0] on_vec;
    logic [RES-1:0] code_vec [NCH];

    // Divisions, updates and idle states act only in the run state
    wire running = (sys_state == PDC_SYS_RUN);
    wire any_rise = |rise_vec;

    // Device power sequence
    always_comb begin
        next_sys_state = sys_state;
        unique case (sys_state)
            PDC_SYS_RUN: begin
                if (!shutdown_n) begin
                    next_sys_state = PDC_SYS_SHUT;
                end
            end
            PDC_SYS_SHUT: begin
                if (shutdown_n) begin
                    if (idle_behaviour_select) begin
                        next_sys_state = PDC_SYS_WAIT;
                    end else begin
                        next_sys_state = PDC_SYS_RUN;
                    end
                end
            end
            PDC_SYS_WAIT: begin
                if (!shutdown_n) begin
                    next_sys_state = PDC_SYS_SHUT;
                end else if (any_rise) begin
                    next_sys_state = PDC_SYS_RUN;
                end
            end
            default: begin
                next_sys_state = PDC_SYS_SHUT;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            // Sample/hold channels start powered down, so run is safe here
            sys_state <= PDC_SYS_RUN;
        end else begin
            sys_state <= next_sys_state;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            logic pin_q;
            logic armed;
            logic idle_seen;
            logic idle_lvl_q;
            logic busy;
            logic chan_on;
            logic drive_q;
            logic upd_q;
            logic [CW-1:0] since;
            logic [CW-1:0] high_acc;
            logic [CW-1:0] period_q;
            logic [CW:0] rem;
            logic [RES-1:0] quo;
            logic [RES-1:0] code;
            logic [SW-1:0] step;

            wire pin = pwm_in[ch];
            // Edges are seen only at clock samples; a narrower pulse is lost
            wire rise = pin & ~pin_q;
            wire [CW-1:0] period = since;
            wire [CW-1:0] high_time = high_acc;
            wire [CW-1:0] low_time = period - high_time;
            wire pair_ok = armed & (period < IDLE_LIM);
            wire too_fast = period < COMP_LIM;
            // Rises while dividing are dropped; the period still restarts
            wire take = running & rise & pair_ok & ~too_fast & ~busy;
            wire force_zero = high_time < HIGH_LIM;
            wire force_full = low_time < LOW_LIM;
            wire start_div = take & ~force_zero & ~force_full;
            // Idle is due past the timeout, once per input level
            wire idle_due = (since >= IDLE_LIM) & (~idle_seen | (pin != idle_lvl_q));
            wire idle_hit = running & ~rise & idle_due;
            wire [CW:0] rem_shift = {rem[CW-1:0], 1'b0};
            wire quo_bit = rem_shift >= {1'b0, period_q};
            wire [CW:0] rem_next = quo_bit ? rem_shift - {1'b0, period_q} : rem_shift;
            wire div_done = busy & (step == STEP_ONE);
            wire [RES-1:0] quo_final = {quo[RES-2:0], quo_bit};
            wire since_sat = (since == CNT_MAX);
            wire high_sat = (high_acc == CNT_MAX);

            // Time base is the clock itself: 10 ns resolves 12 bits up to 24.4 kHz
            always_ff @(posedge clock) begin
                if (srst) begin
                    // Tracking the pin in reset stops a held-high input faking a rise
                    pin_q <= pin;
                    // Counting from reset lets a silent input reach its idle state
                    since <= {CW{1'b0}};
                    high_acc <= {CW{1'b0}};
                end else begin
                    pin_q <= pin;
                    if (rise) begin
                        since <= CNT_ONE;
                        high_acc <= CNT_ONE;
                    end else begin
                        since <= since_sat ? since : since + CNT_ONE;
                        if (pin && !high_sat) begin
                            high_acc <= high_acc + CNT_ONE;
                        end
                    end
                end
            end

            // A first edge only arms; shutdown drops the pending pair
            always_ff @(posedge clock) begin
                if (srst) begin
                    armed <= 1'b0;
                end else if (!running && !rise) begin
                    armed <= 1'b0;
                end else if (rise) begin
                    armed <= 1'b1;
                end
            end

            // Level whose idle state is in force; a high idle that later
            // drops low must still reach the low idle state
            always_ff @(posedge clock) begin
                if (srst || rise) begin
                    idle_seen <= 1'b0;
                    idle_lvl_q <= 1'b0;
                end else if (idle_hit) begin
                    idle_seen <= 1'b1;
                    idle_lvl_q <= pin;
                end
            end

            // Restoring division of high time shifted by N over period
            always_ff @(posedge clock) begin
                if (srst) begin
                    busy <= 1'b0;
                    step <= {SW{1'b0}};
                    rem <= {(CW+1){1'b0}};
                    quo <= CODE_ZERO;
                    period_q <= {CW{1'b0}};
                end else if (start_div) begin
                    busy <= 1'b1;
                    step <= STEPS;
                    rem <= {1'b0, high_time};
                    quo <= CODE_ZERO;
                    period_q <= period;
                end else if (busy) begin
                    rem <= rem_next;
                    quo <= quo_final;
                    step <= step - STEP_ONE;
                    if (div_done || !running) begin
                        busy <= 1'b0;
                    end
                end
            end

            // Code and channel power
            always_ff @(posedge clock) begin
                if (srst) begin
                    code <= CODE_ZERO;
                    chan_on <= ~idle_behaviour_select;
                    upd_q <= 1'b0;
                end else begin
                    upd_q <= 1'b0;
                    if (!running) begin
                        if (idle_behaviour_select) begin
                            chan_on <= 1'b0;
                        end
                    end else if (take && force_zero) begin
                        code <= CODE_ZERO;
                        chan_on <= 1'b1;
                        upd_q <= 1'b1;
                    end else if (take && force_full) begin
                        code <= CODE_FULL;
                        chan_on <= 1'b1;
                        upd_q <= 1'b1;
                    end else if (div_done) begin
                        code <= quo_final;
                        chan_on <= 1'b1;
                        upd_q <= 1'b1;
                    end else if (idle_hit) begin
                        if (!idle_behaviour_select) begin
                            code <= pin ? CODE_FULL : CODE_ZERO;
                            chan_on <= 1'b1;
                            upd_q <= 1'b1;
                        end else if (!pin) begin
                            chan_on <= 1'b0;
                        end
                    end
                end
            end

            // Output driver enable follows power one cycle later
            always_ff @(posedge clock) begin
                if (srst) begin
                    drive_q <= 1'b0;
                end else begin
                    drive_q <= chan_on & running;
                end
            end

            assign rise_vec[ch] = rise;
            assign on_vec[ch] = drive_q;
            assign code_vec[ch] = code;
            assign code_update[ch] = upd_q;
        end
    endgenerate

    // Per-channel results gathered onto the named ports
    assign dac_code_a = code_vec[0];
    assign dac_code_b = code_vec[1];
    assign dac_drive_en = on_vec;

    // Reference control
    wire next_ref_on = ~reference_source_select & running & (|on_vec);

    always_ff @(posedge clock) begin
        if (srst) begin
            internal_ref_enable <= 1'b0;
            ref_pin_oe <= 1'b0;
            ref_external <= 1'b0;
            ref_gain_double <= 1'b0;
        end else begin
            internal_ref_enable <= next_ref_on;
            ref_pin_oe <= next_ref_on;
            // Source and gain follow the select pin even in shutdown
            ref_external <= reference_source_select;
            ref_gain_double <= ~reference_source_select;
        end
    end

endmodule

// file: verif/pdc_checker.sv
`timescale 1ns/1ps
module pdc_checker #(
    parameter int RES = 12,
    parameter int IDLE_CYC = 6000000
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [1:0] pwm_in,
    input wire logic idle_behaviour_select,
    input wire logic reference_source_select,
    input wire logic shutdown_n,
    input wire logic [RES-1:0] dac_code_a,
    input wire logic [1:0] dac_drive_en,
    input wire logic [1:0] code_update,
    input wire logic internal_ref_enable,
    input wire logic ref_pin_oe,
    input wire logic ref_external,
    input wire logic ref_gain_double
);
    logic [31:0] low_run;
    wire idle_low = low_run == 32'(IDLE_CYC + 8);
    // Low time of channel A, stops just past the timeout
    always_ff @(posedge clock) begin
        if (srst || pwm_in[0]) begin
            low_run <= 32'h0;
        end else if (!idle_low) begin
            low_run <= low_run + 32'h1;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    property p_pin_oe; ref_pin_oe == internal_ref_enable; endproperty
    property p_ext_off; $past(reference_source_select) && reference_source_select |=>
        !internal_ref_enable; endproperty
    property p_shut; !shutdown_n [*3] |-> dac_drive_en == 2'h0 && !internal_ref_enable;
    endproperty
    property p_gain; !$past(srst) |-> ref_gain_double == !$past(reference_source_select);
    endproperty
    property p_ext; !$past(srst) |-> ref_external == $past(reference_source_select); endproperty
    property p_keep; $changed(dac_code_a) |-> code_update[0]; endproperty
    property p_wake; idle_behaviour_select && $rose(dac_drive_en[0]) && !$past(srst, 2) |->
        $past(code_update[0]); endproperty
    property p_por; $fell(srst) |=> dac_drive_en == {2{!$past(idle_behaviour_select, 2)}};
    endproperty
    property p_idle_down; idle_behaviour_select && idle_low |-> !dac_drive_en[0]; endproperty
    property p_idle_zero; !idle_behaviour_select && idle_low |-> ~|dac_code_a; endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("ref pin drive mismatch");
    a_ext_off: assert property (p_ext_off) else $error("internal ref on");
    a_shut: assert property (p_shut) else $error("not down in shutdown");
    a_gain: assert property (p_gain) else $error("gain select wrong");
    a_ext: assert property (p_ext) else $error("ref source wrong");
    a_keep: assert property (p_keep) else $error("code moved with no update");
    a_wake: assert property (p_wake) else $error("output on before update");
    a_por: assert property (p_por) else $error("reset power state wrong");
    a_idle_down: assert property (p_idle_down) else $error("idle channel on");
    a_idle_zero: assert property (p_idle_zero) else $error("idle code not zero");
    c_upd: cover property (code_update[0]);
    c_idle: cover property (idle_low);
    c_wake: cover property (idle_behaviour_select && $rose(dac_drive_en[0]));
endmodule
bind pdc_top pdc_checker #(.RES(RES), .IDLE_CYC(IDLE_CYC)) chk_u (.clock(clock), .srst(srst),
    .pwm_in(pwm_in), .idle_behaviour_select(idle_behaviour_select),
    .reference_source_select(reference_source_select), .shutdown_n(shutdown_n),
    .dac_code_a(dac_code_a), .dac_drive_en(dac_drive_en), .code_update(code_update),
    .internal_ref_enable(internal_ref_enable), .ref_pin_oe(ref_pin_oe),
    .ref_external(ref_external), .ref_gain_double(ref_gain_double));

// file: verif/pdc_pwm_src.sv
`timescale 1ns/1ps
module pdc_pwm_src (
    input wire logic clock,
    input wire logic [1:0] run,
    input wire logic [1:0] idle_lvl,
    input wire logic [1:0][11:0] hi,
    input wire logic [1:0][11:0] lo,
    output logic [1:0] pwm
);
    logic [1:0][11:0] cnt = '0;
    logic [1:0][11:0] h = '0;
    logic [1:0][11:0] l = '0;
    // Widths load only at a period start, so no period mixes two settings
    always @(negedge clock) begin
        for (int c = 0; c < 2; c++) begin
            if (!run[c] || {1'b0, cnt[c]} + 13'h1 >= h[c] + l[c]) begin
                h[c] <= hi[c];
                l[c] <= lo[c];
                cnt[c] <= 12'h0;
            end else begin
                cnt[c] <= cnt[c] + 12'h1;
            end
            pwm[c] <= run[c] ? cnt[c] < h[c] : idle_lvl[c];
        end
    end
endmodule

// file: verif/pwm_duty_to_dac_control_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module pwm_duty_to_dac_control_bench;
    localparam int IDLE = 1000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic idle_sel = 1'b0;
    logic ref_sel = 1'b0;
    logic shutdown_n = 1'b1;
    logic [1:0] run = 2'h0;
    logic [1:0] lvl = 2'h0;
    logic [1:0][11:0] hi = '0;
    logic [1:0][11:0] lo = '0;
    logic [1:0] pwm_in, upd, drv;
    logic [11:0] code_a, code_b, keep;
    logic ire, roe, rext, rgd;
    int n_fail = 0;
    int samples_checked = 0;
    int per, h;
    always #5 clock = ~clock;
    pdc_pwm_src src_u (.clock(clock), .run(run), .idle_lvl(lvl), .hi(hi), .lo(lo), .pwm(pwm_in));
    pdc_top #(.IDLE_CYC(IDLE)) dut_u (.clock(clock), .srst(srst), .pwm_in(pwm_in),
        .idle_behaviour_select(idle_sel), .reference_source_select(ref_sel),
        .shutdown_n(shutdown_n), .dac_code_a(code_a), .dac_code_b(code_b), .dac_drive_en(drv),
        .code_update(upd), .internal_ref_enable(ire), .ref_pin_oe(roe), .ref_external(rext),
        .ref_gain_double(rgd));
    function automatic logic [11:0] exp_code(int hw, int lw);
        if (hw < 2) return 12'h000;
        if (lw < 2) return 12'hfff;
        return 12'((hw << 12) / (hw + lw));
    endfunction
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic rst(logic s);
        idle_sel = s;
        srst = 1'b1;
        repeat (5) @(negedge clock);
        srst = 1'b0;
        repeat (3) @(negedge clock);
        `CHK("drive", {2{~s}}, drv)
        `CHK("code", 12'h000, code_a)
    endtask
    task automatic set_w(int c, int hw, int lw, logic r, logic v);
        @(posedge clock);
        hi[c] = 12'(hw);
        lo[c] = 12'(lw);
        run[c] = r;
        lvl[c] = v;
        @(negedge clock);
    endtask
    task automatic wait_upd(int c);
        int i;
        for (i = 0; i < 3000 && upd[c] !== 1'b1; i++) @(negedge clock);
        `CHK("update", 1'b1, upd[c])
        @(negedge clock);
    endtask
    // First pulse seen may still carry the old widths, so the third is checked
    task automatic pwm_set(int c, int hw, int lw);
        set_w(c, hw, lw, 1'b1, lvl[c]);
        repeat (3) wait_upd(c);
        `CHK("code", exp_code(hw, lw), c ? code_b : code_a)
    endtask
    initial begin
        void'($urandom(83));
        rst(1'b0);
        `CHK("iref", 1'b1, ire)
        `CHK("gain", 1'b1, rgd)
        pwm_set(0, 1, 600);
        pwm_set(0, 600, 1);
        for (int k = 0; k < 8; k++) begin
            per = 330 + $urandom % 600;
            h = 2 + $urandom % (per - 3);
            pwm_set(k % 2, h, per - h);
        end
        keep = code_a;
        set_w(0, 100, 100, 1'b1, 1'b0);
        repeat (1500) @(negedge clock);
        `CHK("code", keep, code_a)
        set_w(0, 1, 1, 1'b0, 1'b0);
        set_w(1, 1, 1, 1'b0, 1'b1);
        repeat (IDLE + 600) @(negedge clock);
        `CHK("code", 12'h000, code_a)
        `CHK("code", 12'hfff, code_b)
        set_w(1, 1, 1, 1'b0, 1'b0);
        repeat (3) @(negedge clock);
        `CHK("code", 12'h000, code_b)
        shutdown_n = 1'b0;
        repeat (3) @(negedge clock);
        `CHK("drive", 2'h0, drv)
        `CHK("iref", 1'b0, ire)
        `CHK("ref pin", 1'b0, roe)
        shutdown_n = 1'b1;
        repeat (3) @(negedge clock);
        `CHK("drive", 2'h3, drv)
        ref_sel = 1'b1;
        repeat (3) @(negedge clock);
        `CHK("ext", 1'b1, rext)
        `CHK("gain", 1'b0, rgd)
        `CHK("iref", 1'b0, ire)
        ref_sel = 1'b0;
        $display("test transparent finished");
        rst(1'b1);
        `CHK("iref", 1'b0, ire)
        pwm_set(0, 200, 400);
        `CHK("drive", 2'h1, drv)
        set_w(0, 200, 400, 1'b0, 1'b1);
        repeat (700) @(negedge clock);
        keep = code_a;
        repeat (IDLE + 50) @(negedge clock);
        `CHK("code", keep, code_a)
        `CHK("drive", 2'h1, drv)
        shutdown_n = 1'b0;
        repeat (3) @(negedge clock);
        shutdown_n = 1'b1;
        repeat (50) @(negedge clock);
        `CHK("drive", 2'h0, drv)
        pwm_set(0, 300, 300);
        `CHK("drive", 2'h1, drv)
        set_w(0, 1, 1, 1'b0, 1'b0);
        repeat (IDLE + 50) @(negedge clock);
        `CHK("drive", 2'h0, drv)
        $display("test hold finished");
        finish_test();
    end
    initial begin
        #950000;
        n_fail++;
        finish_test();
    end
endmodule
